// ### hw/ccr_pkg.sv
// Constants, register map and field layout of the configuration registers.
// Assumes a 100 MHz core clock and an 8-bit register port from the local I2C target.
// Operation
// - Abort a control-channel transaction outliving the watchdog timeout.
// - Timeout field 7:1 counts 2 ms units; register resets to FE.
// - Bit 0 set disables the watchdog; clear lets it run.
// - Bit 7 clear forwards remote IDs only; set forwards all but own ID.
// - With second port selected, forward-all bit belongs to that port.
// - Delay data sampling by hold field 6:4 in 40 ns steps.
// - Reject clock and data glitches up to filter field 3:0 times 5 ns.
// - Master clock high lasts count plus five units; resets 7F.
// - Master clock low lasts low count plus five units; resets 7F.
// - As target, stretch the clock for the low count while data settles.
// - Default counts give at least 5 us per phase at the fast oscillator.
// - Read-only bit 3 mirrors the strapped auxiliary audio enable.
// - Bit 1 selects wide 28-bit words; clear gives 24 bits plus three controls.
// - Bit 0 set enables surround audio; clear leaves two or four channel audio.
// - Surround audio uses only the data-island transport path.
// - A repeater may override surround enable from in-band audio mode.
// - Count back-channel CRC errors in self-test, eight bits, saturating at 255.
// - Error counter clears on a new self-test run or a software clear.
// - With second port selected, the error counter reports second port errors.
// - Self-test runs while its enable is one; enable resets to zero.
package ccr_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_WDOG_CTL = 8'h16;
  localparam logic [7:0] ADDR_FWD_CTL = 8'h17;
  localparam logic [7:0] ADDR_SCL_HIGH = 8'h18;
  localparam logic [7:0] ADDR_SCL_LOW = 8'h19;
  localparam logic [7:0] ADDR_DATAPATH2 = 8'h1A;
  localparam logic [7:0] ADDR_BC_ERR_CNT = 8'h1B;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_WDOG_CTL = 8'hFE;
  localparam logic [7:0] RST_FWD_CTL = 8'h1E;
  localparam logic [7:0] RST_SCL_HIGH = 8'h7F;
  localparam logic [7:0] RST_SCL_LOW = 8'h7F;
  localparam logic [1:0] RST_DATAPATH2 = 2'h0;
  localparam logic [7:0] RST_BC_ERR_CNT = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int WDOG_DISABLE_BIT = 0;
  localparam int WDOG_TIMEOUT_LSB = 1;
  localparam int FWD_PASS_ALL_BIT = 7;
  localparam int FWD_HOLD_LSB = 4;
  localparam int FWD_FILTER_LSB = 0;
  localparam int DP2_AUX_AUDIO_BIT = 3;
  localparam int DP2_WIDE_WORD_BIT = 1;
  localparam int DP2_SURROUND_BIT = 0;
  localparam logic [7:0] BC_ERR_MAX = 8'hFF;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WDOG_UNIT_MS = 2;
  localparam int WDOG_TICK_CYC = WDOG_UNIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int HOLD_STEP_NS = 40;
  localparam int HOLD_STEP_CYC = (HOLD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_MAX_CYC = 7 * HOLD_STEP_CYC;
  localparam int FILT_STEP_NS = 5;
  localparam real SCL_UNIT_NS = 38.0952;
  localparam int SCL_UNIT_CYC = int'($ceil(SCL_UNIT_NS / CLK_PERIOD_NS));
  localparam int SCL_EXTRA_UNITS = 5;

  typedef enum logic [1:0] {
    CCR_SCL_IDLE,
    CCR_SCL_HIGH,
    CCR_SCL_LOW,
    CCR_SCL_STRETCH
  } ccr_scl_state_t;

endpackage

// ### hw/ccr_watchdog.sv
// Control-channel watchdog: times a transaction in 2 ms ticks.
// Assumes start and done are core-clock pulses.
`timescale 1ns/1ns
module ccr_watchdog
  import ccr_pkg::*;
#(
  parameter int TICK_CYCLES = WDOG_TICK_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_enable,
  input wire logic [6:0] i_timeout,
  input wire logic i_txn_start,
  input wire logic i_txn_done,
  output logic o_busy,
  output logic o_abort
);

  logic [17:0] tick_cnt;
  logic [6:0] unit_cnt;
  logic tick;

  assign tick = (tick_cnt == 18'(TICK_CYCLES - 1));

  // ==========================================================================
  // Tick and unit counters
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_cnt <= '0;
      unit_cnt <= '0;
    end else if (i_txn_start || !o_busy) begin
      tick_cnt <= '0;
      unit_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
      unit_cnt <= unit_cnt + 7'h01;
    end else begin
      tick_cnt <= tick_cnt + 18'h00001;
    end
  end

  // ==========================================================================
  // Transaction tracking and abort
  // A zero timeout aborts at the first tick; software must not set it.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_busy <= 1'b0;
      o_abort <= 1'b0;
    end else begin
      o_abort <= 1'b0;
      if (i_txn_start && i_enable) begin
        o_busy <= 1'b1;
      end else if (i_txn_done || !i_enable) begin
        o_busy <= 1'b0;
      end else if (o_busy && tick && (unit_cnt + 7'h01 >= i_timeout)) begin
        o_busy <= 1'b0;
        o_abort <= 1'b1;
      end
    end
  end

endmodule

// ### hw/ccr_link_err.sv
// Link-side capture of back-channel CRC errors for both ports.
// Runs on the link clock; each error flips a toggle the core resynchronises.
`timescale 1ns/1ns
module ccr_link_err
  import ccr_pkg::*;
(
  input wire logic i_link_clk,
  input wire logic i_rst_b,
  input wire logic [1:0] i_bc_crc_err,
  output logic [1:0] o_err_toggle
);

  // ==========================================================================
  // Event toggles
  // A toggle survives the slower sampling side, unlike a one-cycle pulse.
  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_err_toggle <= 2'h0;
    end else begin
      o_err_toggle <= o_err_toggle ^ i_bc_crc_err;
    end
  end

endmodule

// ### hw/ccr_regs.sv
// Control-channel, I2C timing and data-path registers with their logic.
// Assumes an 8-bit register port from the I2C target and a link clock for errors.
`timescale 1ns/1ns
module ccr_regs
  import ccr_pkg::*;
#(
  parameter int WDOG_TICK_CYCLES = WDOG_TICK_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_link_clk,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_second_port_select,
  input wire logic i_cc_txn_start,
  input wire logic i_cc_txn_done,
  output logic o_cc_busy,
  output logic o_cc_abort,
  input wire logic i_access_valid,
  input wire logic [6:0] i_access_target_id,
  input wire logic [6:0] i_own_target_id,
  input wire logic [6:0] i_remote_deser_id,
  input wire logic [6:0] i_remote_target_id,
  output logic o_forward_port0,
  output logic o_forward_port1,
  input wire logic i_scl_in,
  input wire logic i_sda_in,
  output logic o_scl_filtered,
  output logic o_sda_sampled,
  input wire logic i_master_run,
  input wire logic i_stretch_req,
  output logic o_scl_out,
  output logic o_scl_oe_b,
  output logic o_stretch_release,
  input wire logic i_aux_audio_strap,
  input wire logic i_repeater_mode,
  input wire logic i_inband_valid,
  input wire logic i_inband_surround,
  output logic o_wide_word_mode,
  output logic o_surround_enable,
  output logic o_island_transport_only,
  input wire logic i_selftest_enable,
  input wire logic i_err_count_clear,
  input wire logic [1:0] i_bc_crc_err
);

  // ==========================================================================
  // Functions
  function automatic logic [3:0] filt_cycles(input logic [3:0] depth);
    int ns;
    ns = int'(depth) * FILT_STEP_NS;
    return 4'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

  function automatic logic [10:0] phase_cycles(input logic [7:0] count);
    return 11'((int'(count) + SCL_EXTRA_UNITS) * SCL_UNIT_CYC);
  endfunction

  // ==========================================================================
  // Register storage
  logic [7:0] wdog_ctl;
  logic [6:0] fwd_ctl_low;
  logic [1:0] pass_all;
  logic [7:0] scl_high;
  logic [7:0] scl_low;
  logic [1:0] datapath2;
  logic [7:0] err_cnt [2];
  logic aux_audio;
  logic aux_audio_taken;

  logic wr_wdog;
  logic wr_fwd;
  logic wr_high;
  logic wr_low;
  logic wr_dp2;

  assign wr_wdog = i_reg_wr && (i_reg_addr == ADDR_WDOG_CTL);
  assign wr_fwd = i_reg_wr && (i_reg_addr == ADDR_FWD_CTL);
  assign wr_high = i_reg_wr && (i_reg_addr == ADDR_SCL_HIGH);
  assign wr_low = i_reg_wr && (i_reg_addr == ADDR_SCL_LOW);
  assign wr_dp2 = i_reg_wr && (i_reg_addr == ADDR_DATAPATH2);

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wdog_ctl <= RST_WDOG_CTL;
    end else if (wr_wdog) begin
      wdog_ctl <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fwd_ctl_low <= RST_FWD_CTL[6:0];
      pass_all <= {2{RST_FWD_CTL[FWD_PASS_ALL_BIT]}};
    end else if (wr_fwd) begin
      fwd_ctl_low <= i_reg_wdata[6:0];
      pass_all[i_second_port_select] <= i_reg_wdata[FWD_PASS_ALL_BIT];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_high <= RST_SCL_HIGH;
    end else if (wr_high) begin
      scl_high <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_low <= RST_SCL_LOW;
    end else if (wr_low) begin
      scl_low <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      datapath2 <= RST_DATAPATH2;
    end else if (wr_dp2) begin
      datapath2 <= i_reg_wdata[1:0];
    end
  end

  // The strap is caught once, on the first edge after reset release.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aux_audio <= 1'b0;
      aux_audio_taken <= 1'b0;
    end else if (!aux_audio_taken) begin
      aux_audio <= i_aux_audio_strap;
      aux_audio_taken <= 1'b1;
    end
  end

  // ==========================================================================
  // Register read
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        ADDR_WDOG_CTL: o_reg_rdata <= wdog_ctl;
        ADDR_FWD_CTL: o_reg_rdata <= {pass_all[i_second_port_select], fwd_ctl_low};
        ADDR_SCL_HIGH: o_reg_rdata <= scl_high;
        ADDR_SCL_LOW: o_reg_rdata <= scl_low;
        ADDR_DATAPATH2: o_reg_rdata <= {4'h0, aux_audio, 1'b0, datapath2};
        ADDR_BC_ERR_CNT: o_reg_rdata <= err_cnt[i_second_port_select];
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Watchdog
  ccr_watchdog #(
    .TICK_CYCLES(WDOG_TICK_CYCLES)
  ) u_watchdog (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_enable(!wdog_ctl[WDOG_DISABLE_BIT]),
    .i_timeout(wdog_ctl[7:WDOG_TIMEOUT_LSB]),
    .i_txn_start(i_cc_txn_start),
    .i_txn_done(i_cc_txn_done),
    .o_busy(o_cc_busy),
    .o_abort(o_cc_abort)
  );

  // ==========================================================================
  // Forwarding policy
  logic remote_hit;
  logic fwd_any;

  assign remote_hit = (i_access_target_id == i_remote_deser_id) ||
                      (i_access_target_id == i_remote_target_id);
  assign fwd_any = i_access_valid && (i_access_target_id != i_own_target_id);

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_forward_port0 <= 1'b0;
      o_forward_port1 <= 1'b0;
    end else begin
      o_forward_port0 <= fwd_any && (pass_all[0] || remote_hit);
      o_forward_port1 <= fwd_any && (pass_all[1] || remote_hit);
    end
  end

  // ==========================================================================
  // Pin synchronisers and glitch filter
  logic [1:0] line_meta;
  logic [1:0] line_sync;
  logic [1:0] line_filt;
  logic [3:0] filt_cnt [2];
  logic [3:0] filt_len;

  assign filt_len = filt_cycles(fwd_ctl_low[FWD_FILTER_LSB +: 4]);

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      line_meta <= 2'h3;
      line_sync <= 2'h3;
    end else begin
      line_meta <= {i_sda_in, i_scl_in};
      line_sync <= line_meta;
    end
  end

  // A change is taken once it outlasts the filter depth.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      line_filt <= 2'h3;
      filt_cnt[0] <= 4'h0;
      filt_cnt[1] <= 4'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (line_sync[i] == line_filt[i]) begin
          filt_cnt[i] <= 4'h0;
        end else if (filt_cnt[i] >= filt_len) begin
          line_filt[i] <= line_sync[i];
          filt_cnt[i] <= 4'h0;
        end else begin
          filt_cnt[i] <= filt_cnt[i] + 4'h1;
        end
      end
    end
  end

  assign o_scl_filtered = line_filt[0];

  // ==========================================================================
  // Data hold delay
  logic [HOLD_MAX_CYC-1:0] sda_hist;
  logic [2:0] hold_steps;
  logic [4:0] hold_cyc;

  assign hold_steps = fwd_ctl_low[FWD_HOLD_LSB +: 3];
  assign hold_cyc = 5'(int'(hold_steps) * HOLD_STEP_CYC);

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sda_hist <= '1;
    end else begin
      sda_hist <= {sda_hist[HOLD_MAX_CYC-2:0], line_filt[1]};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sda_sampled <= 1'b1;
    end else if (hold_cyc == 5'h00) begin
      o_sda_sampled <= line_filt[1];
    end else begin
      o_sda_sampled <= sda_hist[hold_cyc - 5'h01];
    end
  end

  // ==========================================================================
  // Master clock generator and target stretch
  ccr_scl_state_t scl_state;
  ccr_scl_state_t next_scl_state;
  logic [10:0] phase_cnt;
  logic phase_done;

  assign phase_done = (scl_state == CCR_SCL_HIGH) ? (phase_cnt >= phase_cycles(scl_high) - 11'h1)
                                                   : (phase_cnt >= phase_cycles(scl_low) - 11'h1);

  always_comb begin
    next_scl_state = scl_state;
    unique case (scl_state)
      CCR_SCL_IDLE: begin
        if (i_stretch_req) begin
          next_scl_state = CCR_SCL_STRETCH;
        end else if (i_master_run) begin
          next_scl_state = CCR_SCL_LOW;
        end
      end
      CCR_SCL_LOW: begin
        if (phase_done) begin
          next_scl_state = CCR_SCL_HIGH;
        end
      end
      CCR_SCL_HIGH: begin
        if (phase_done) begin
          next_scl_state = i_master_run ? CCR_SCL_LOW : CCR_SCL_IDLE;
        end
      end
      CCR_SCL_STRETCH: begin
        if (phase_done) begin
          next_scl_state = CCR_SCL_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_state <= CCR_SCL_IDLE;
      phase_cnt <= 11'h000;
    end else begin
      scl_state <= next_scl_state;
      phase_cnt <= (next_scl_state != scl_state) ? 11'h000 : phase_cnt + 11'h001;
    end
  end

  // The pin is open drain: only low is ever driven.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_scl_oe_b <= 1'b1;
      o_stretch_release <= 1'b0;
    end else begin
      o_scl_oe_b <= !((next_scl_state == CCR_SCL_LOW) || (next_scl_state == CCR_SCL_STRETCH));
      o_stretch_release <= (scl_state == CCR_SCL_STRETCH) && phase_done;
    end
  end

  assign o_scl_out = 1'b0;

  // ==========================================================================
  // Data path options
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wide_word_mode <= 1'b0;
      o_surround_enable <= 1'b0;
      o_island_transport_only <= 1'b0;
    end else begin
      o_wide_word_mode <= datapath2[DP2_WIDE_WORD_BIT];
      if (i_repeater_mode && i_inband_valid) begin
        o_surround_enable <= i_inband_surround;
        o_island_transport_only <= i_inband_surround;
      end else begin
        o_surround_enable <= datapath2[DP2_SURROUND_BIT];
        o_island_transport_only <= datapath2[DP2_SURROUND_BIT];
      end
    end
  end

  // ==========================================================================
  // Back-channel error counters
  logic [1:0] err_toggle;
  logic [1:0] err_meta;
  logic [1:0] err_sync;
  logic [1:0] err_seen;
  logic [1:0] err_event;
  logic selftest_d;
  logic selftest_start;

  ccr_link_err u_link_err (
    .i_link_clk(i_link_clk),
    .i_rst_b(i_rst_b),
    .i_bc_crc_err(i_bc_crc_err),
    .o_err_toggle(err_toggle)
  );

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      err_meta <= 2'h0;
      err_sync <= 2'h0;
      err_seen <= 2'h0;
    end else begin
      err_meta <= err_toggle;
      err_sync <= err_meta;
      err_seen <= err_sync;
    end
  end

  assign err_event = err_sync ^ err_seen;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      selftest_d <= 1'b0;
    end else begin
      selftest_d <= i_selftest_enable;
    end
  end

  assign selftest_start = i_selftest_enable && !selftest_d;

  // An error in the clearing cycle is kept: count restarts at one.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      err_cnt[0] <= RST_BC_ERR_CNT;
      err_cnt[1] <= RST_BC_ERR_CNT;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (selftest_start || i_err_count_clear) begin
          err_cnt[p] <= (err_event[p] && i_selftest_enable) ? 8'h01 : 8'h00;
        end else if (err_event[p] && i_selftest_enable && (err_cnt[p] != BC_ERR_MAX)) begin
          err_cnt[p] <= err_cnt[p] + 8'h01;
        end
      end
    end
  end

endmodule

// ### verification/ccr_far_model.sv
// Far-side model: remote end reporting back-channel CRC errors per port.
// Assumes the bench calls send_errors and runs the link clock.
`timescale 1ns/1ns
module ccr_far_model (
  input wire logic i_link_clk,
  output logic [1:0] o_bc_crc_err
);
  // ==========
  // Error source
  initial o_bc_crc_err = 2'h0;
  // Five link cycles apart, so the core never merges two pulses.
  task automatic send_errors(input int port, input int n);
    repeat (n) begin
      @(posedge i_link_clk);
      o_bc_crc_err[port] <= 1'b1;
      @(posedge i_link_clk);
      o_bc_crc_err[port] <= 1'b0;
      repeat (3) @(posedge i_link_clk);
    end
  endtask
endmodule

// ### verification/ccr_regs_checker.sv
// Port-level assertions for the register block.
// Bound into ccr_regs; shadows watchdog and pass-all writes.
`timescale 1ns/1ns
module ccr_regs_checker
  import ccr_pkg::*;
#(
  parameter int WDOG_TICK_CYCLES = WDOG_TICK_CYC
) (
  input logic i_core_clk,
  input logic i_rst_b,
  input logic i_reg_wr,
  input logic i_reg_rd,
  input logic [7:0] i_reg_addr,
  input logic [7:0] i_reg_wdata,
  input logic [7:0] o_reg_rdata,
  input logic i_second_port_select,
  input logic i_cc_txn_start,
  input logic i_cc_txn_done,
  input logic o_cc_busy,
  input logic o_cc_abort,
  input logic i_access_valid,
  input logic [6:0] i_access_target_id,
  input logic [6:0] i_own_target_id,
  input logic [6:0] i_remote_deser_id,
  input logic [6:0] i_remote_target_id,
  input logic o_forward_port0,
  input logic o_forward_port1,
  input logic o_scl_out,
  input logic o_scl_oe_b,
  input logic o_stretch_release
);
  // ==========
  // Shadow state
  logic [7:0] wd;
  logic [1:0] pa;
  int cnt;
  int due;
  logic hit;
  logic rem;
  assign due = int'(wd[7:1]) * WDOG_TICK_CYCLES;
  assign hit = i_access_valid && i_access_target_id != i_own_target_id;
  assign rem = i_access_target_id == i_remote_deser_id || i_access_target_id == i_remote_target_id;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) wd <= RST_WDOG_CTL;
    else if (i_reg_wr && i_reg_addr == ADDR_WDOG_CTL) wd <= i_reg_wdata;
  end
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) pa <= 2'h0;
    else if (i_reg_wr && i_reg_addr == ADDR_FWD_CTL) pa[i_second_port_select] <= i_reg_wdata[7];
  end
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) cnt <= 0;
    else if (i_cc_txn_start) cnt <= 0;
    else cnt <= cnt + 1;
  end
  // ==========
  // Properties
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  sequence timed_start;
    i_cc_txn_start && !i_cc_txn_done && !wd[0] && wd[7:1] > 7'h01;
  endsequence
  sequence held_off;
    wd[0] ##1 wd[0];
  endsequence
  start_busy_a: assert property (timed_start |=> o_cc_busy)
    else $error("busy not raised after start");
  abort_time_a: assert property (o_cc_abort |-> cnt >= due - 1 && cnt <= due + 2)
    else $error("abort outside the programmed timeout");
  abort_pulse_a: assert property (o_cc_abort |-> !o_cc_busy ##1 !o_cc_abort)
    else $error("abort not a single pulse ending busy");
  done_idle_a: assert property (i_cc_txn_done && !i_cc_txn_start |=> !o_cc_busy)
    else $error("busy after transaction done");
  wdog_off_a: assert property (held_off |-> !o_cc_busy && !o_cc_abort)
    else $error("watchdog active while disabled");
  fwd_port0_a: assert property (o_forward_port0 == $past(hit && (pa[0] || rem)))
    else $error("port 0 forward decision wrong");
  fwd_port1_a: assert property (o_forward_port1 == $past(hit && (pa[1] || rem)))
    else $error("port 1 forward decision wrong");
  rd_wdog_a: assert property (i_reg_rd && !i_reg_wr && i_reg_addr == ADDR_WDOG_CTL
    |=> o_reg_rdata == $past(wd)) else $error("watchdog register read wrong");
  scl_drive_a: assert property (o_scl_out == 1'b0)
    else $error("clock pin not open drain");
  release_edge_a: assert property (o_stretch_release |-> o_scl_oe_b && !$past(o_scl_oe_b))
    else $error("stretch release without clock release");
endmodule

bind ccr_regs ccr_regs_checker #(.WDOG_TICK_CYCLES(WDOG_TICK_CYCLES)) chk (.*);

// ### verification/ccr_regs_test.sv
// Self-checking bench for the configuration register block.
// Assumes ccr_regs with a 20-cycle watchdog tick and the far-side error model.
`timescale 1ns/1ns
module ccr_regs_test;
  import ccr_pkg::*;
  logic i_core_clk = 1'b0, i_link_clk = 1'b0, i_rst_b = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00;
  logic i_second_port_select = 1'b0, i_cc_txn_start = 1'b0, i_cc_txn_done = 1'b0;
  logic i_access_valid = 1'b0, i_scl_in = 1'b1, i_sda_in = 1'b1, i_master_run = 1'b0;
  logic i_stretch_req = 1'b0, i_aux_audio_strap = 1'b1, i_repeater_mode = 1'b0;
  logic i_inband_valid = 1'b0, i_inband_surround = 1'b0, i_selftest_enable = 1'b0;
  logic i_err_count_clear = 1'b0;
  logic [6:0] i_access_target_id = 7'h00, i_own_target_id = 7'h10;
  logic [6:0] i_remote_deser_id = 7'h20, i_remote_target_id = 7'h30;
  logic [1:0] i_bc_crc_err;
  logic [7:0] o_reg_rdata;
  logic o_cc_busy, o_cc_abort, o_forward_port0, o_forward_port1, o_scl_filtered, o_sda_sampled;
  logic o_scl_out, o_scl_oe_b, o_stretch_release, o_wide_word_mode, o_surround_enable;
  logic o_island_transport_only;
  logic [7:0] rv [6] = '{8'hFE, 8'h1E, 8'h7F, 8'h7F, 8'h08, 8'h00};
  int fail_count = 0, tests_run = 0, cyc = 0;
  ccr_regs #(.WDOG_TICK_CYCLES(20)) uut (.*);
  ccr_far_model far (.i_link_clk(i_link_clk), .o_bc_crc_err(i_bc_crc_err));
  always #5 i_core_clk = ~i_core_clk;
  initial begin
    #3;
    forever #15 i_link_clk = ~i_link_clk;
  end
  // ==========
  // Access tasks
  task automatic test_done();
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_core_clk);
    i_reg_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(negedge i_core_clk);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(negedge i_core_clk);
    i_reg_rd = 1'b0;
    chk(o_reg_rdata & m, e & m);
  endtask
  task automatic pulse(input int w);
    @(negedge i_core_clk);
    {i_cc_txn_start, i_cc_txn_done, i_stretch_req, i_err_count_clear} = 4'h8 >> w;
    @(negedge i_core_clk);
    {i_cc_txn_start, i_cc_txn_done, i_stretch_req, i_err_count_clear} = 4'h0;
  endtask
  task automatic ec(input logic [7:0] e);
    rd_chk(ADDR_BC_ERR_CNT, 8'hFF, e);
  endtask
  task automatic fwd(input logic [6:0] id, input logic [1:0] e);
    @(negedge i_core_clk);
    i_access_valid = 1'b1;
    i_access_target_id = id;
    @(negedge i_core_clk);
    chk({o_forward_port1, o_forward_port0}, e);
    i_access_valid = 1'b0;
  endtask
  task automatic wait_abort(output int n);
    n = 0;
    while (o_cc_abort !== 1'b1 && n < 120) begin
      @(negedge i_core_clk);
      n++;
    end
  endtask
  task automatic span(input logic lvl, output int n);
    n = 0;
    for (int k = 0; k < 700 && o_scl_oe_b !== lvl; k++) @(negedge i_core_clk);
    while (o_scl_oe_b === lvl && n < 700) begin
      @(negedge i_core_clk);
      n++;
    end
  endtask
  // ==========
  // Timeout
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end
  // ==========
  // Scenarios
  initial begin
    int n;
    logic v;
    repeat (5) @(negedge i_core_clk);
    i_rst_b = 1'b1;
    for (int k = 0; k < 6; k++) begin
      rd_chk(ADDR_WDOG_CTL + 8'(k), k == 4 ? 8'hFB : 8'hFF, rv[k]);
    end
    rd_chk(8'h20, 8'hFF, 8'h00);
    i_master_run = 1'b1;
    span(1'b0, n);
    chk(8'(n / 4), 8'(132));
    span(1'b1, n);
    chk(8'(n / 4), 8'(132));
    i_master_run = 1'b0;
    repeat (600) @(negedge i_core_clk);
    wr(ADDR_SCL_HIGH, 8'h02);
    wr(ADDR_SCL_LOW, 8'h03);
    i_master_run = 1'b1;
    span(1'b0, n);
    chk(8'(n), 8'd32);
    span(1'b1, n);
    chk(8'(n), 8'd28);
    i_master_run = 1'b0;
    repeat (60) @(negedge i_core_clk);
    pulse(2);
    span(1'b0, n);
    chk(8'(n), 8'd32);
    wr(ADDR_WDOG_CTL, 8'h04);
    pulse(0);
    chk(o_cc_busy, 1'b1);
    repeat (30) @(negedge i_core_clk);
    pulse(0);
    wait_abort(n);
    chk(n >= 39 && n <= 41, 1'b1);
    pulse(0);
    pulse(1);
    wait_abort(n);
    chk(n == 120, 1'b1);
    wr(ADDR_WDOG_CTL, 8'h05);
    pulse(0);
    wait_abort(n);
    chk({o_cc_busy, n == 120}, 8'h01);
    fwd(7'h20, 2'h3);
    fwd(7'h30, 2'h3);
    fwd(7'h40, 2'h0);
    wr(ADDR_FWD_CTL, 8'h9E);
    fwd(7'h40, 2'h1);
    fwd(7'h10, 2'h0);
    i_second_port_select = 1'b1;
    rd_chk(ADDR_FWD_CTL, 8'hFF, 8'h1E);
    wr(ADDR_FWD_CTL, 8'h9E);
    fwd(7'h40, 2'h3);
    wr(ADDR_FWD_CTL, 8'h1E);
    fwd(7'h40, 2'h1);
    i_second_port_select = 1'b0;
    rd_chk(ADDR_FWD_CTL, 8'hFF, 8'h9E);
    wr(ADDR_FWD_CTL, 8'h0F);
    i_scl_in = 1'b0;
    repeat (3) @(negedge i_core_clk);
    i_scl_in = 1'b1;
    v = 1'b1;
    repeat (16) @(negedge i_core_clk) v &= o_scl_filtered;
    chk(v, 1'b1);
    {i_scl_in, i_sda_in} = 2'h0;
    repeat (16) @(negedge i_core_clk);
    chk({o_scl_filtered, o_sda_sampled}, 8'h00);
    {i_scl_in, i_sda_in} = 2'h3;
    wr(ADDR_DATAPATH2, 8'hFF);
    rd_chk(ADDR_DATAPATH2, 8'hFB, 8'h0B);
    chk({o_wide_word_mode, o_surround_enable, o_island_transport_only}, 8'h07);
    wr(ADDR_DATAPATH2, 8'h00);
    {i_repeater_mode, i_inband_valid, i_inband_surround} = 3'h7;
    rd_chk(ADDR_DATAPATH2, 8'hFB, 8'h08);
    chk({o_wide_word_mode, o_surround_enable}, 8'h01);
    {i_repeater_mode, i_inband_valid, i_inband_surround} = 3'h0;
    wr(ADDR_BC_ERR_CNT, 8'h55);
    i_selftest_enable = 1'b1;
    far.send_errors(0, 3);
    ec(8'h03);
    i_second_port_select = 1'b1;
    far.send_errors(1, 2);
    ec(8'h02);
    i_second_port_select = 1'b0;
    far.send_errors(0, 260);
    ec(8'hFF);
    i_selftest_enable = 1'b0;
    pulse(1);
    i_selftest_enable = 1'b1;
    ec(8'h00);
    far.send_errors(0, 2);
    pulse(3);
    ec(8'h00);
    i_selftest_enable = 1'b0;
    far.send_errors(0, 2);
    ec(8'h00);
    test_done();
  end
endmodule
